// ---- core/rre_pkg.sv ----
/*
 * rre_pkg: shared constants for the return and rotate execution block.
 * Assumes a 14-bit instruction word, an 8-bit data path and a 13-bit program counter.
 */
package rre_pkg;
    // widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int STACK_DEPTH = 8;
    // opcode patterns and masks
    localparam logic [INSTR_W-1:0] OPC_RET_INT = 14'h0009;
    localparam logic [INSTR_W-1:0] OPC_RET_LIT_MASK = 14'h3c00;
    localparam logic [INSTR_W-1:0] OPC_RET_LIT_VAL = 14'h3400;
    localparam logic [INSTR_W-1:0] OPC_ROT_MASK = 14'h3f00;
    localparam logic [INSTR_W-1:0] OPC_ROT_VAL = 14'h0d00;
    // field positions
    localparam int DEST_BIT = 7;
    localparam int GIE_BIT = 7;
    localparam int MSB_BIT = 7;
    // cycle counts
    localparam int RET_CYCLES = 2;
    localparam int ROT_CYCLES = 1;
    // reset values
    localparam logic [DATA_W-1:0] W_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic CARRY_RST = 1'b0;
    localparam logic GIE_RST = 1'b0;
    // decoded operation
    typedef enum logic [1:0] {
        RRE_OP_NONE = 2'b00,
        RRE_OP_RET_INT = 2'b01,
        RRE_OP_RET_LIT = 2'b10,
        RRE_OP_ROT = 2'b11
    } rre_op_e;
    // sequencer states
    typedef enum logic [0:0] {
        RRE_ST_IDLE = 1'b0,
        RRE_ST_RET = 1'b1
    } rre_state_e;
endpackage : rre_pkg

// ---- core/rre_stack.sv ----
/*
 * rre_stack: circular hardware return stack with registered read data.
 * Assumes the caller never pushes and pops in the same enabled cycle.
 */
`timescale 1ns/1ps
module rre_stack #(
    parameter int DEPTH = rre_pkg::STACK_DEPTH,
    parameter int WIDTH = rre_pkg::PC_W
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    output logic [WIDTH-1:0] rd_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // depth must be a power of two for the wrapping pointer
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("rre_stack: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] sp;
        logic [WIDTH-1:0] rd;
    } rre_stack_s;

    rre_stack_s stk_reg;
    rre_stack_s stk_next;
    logic [PTR_W-1:0] top_idx;

    assign top_idx = stk_reg.sp - 1'b1;

    // push writes the free slot, pop latches the top and steps back
    always_comb begin
        stk_next = stk_reg;
        if (push_i) begin
            stk_next.mem[stk_reg.sp] = push_data_i;
            stk_next.sp = stk_reg.sp + 1'b1;
        end else if (pop_i) begin
            stk_next.rd = stk_reg.mem[top_idx];
            stk_next.sp = top_idx;
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stk_reg <= '0;
        end else if (ce_i) begin
            stk_reg <= stk_next;
        end
    end

    assign rd_data_o = stk_reg.rd;
endmodule : rre_stack

// ---- core/rre_core.sv ----
/*
 * rre_core: decode and execute of return-from-interrupt, return-with-literal
 * and rotate-left-through-carry.
 * Assumes the fetch unit offers one instruction at a time with valid/ready,
 * a file-register port with combinational read data and a registered write,
 * and that calls push their return address through the push port.
 * A return must not be taken in a cycle that also pushes: the push wins
 * and the pop is lost, so the fetch side has to keep the two apart.
 */
`timescale 1ns/1ps
// Behaviour
// - return-from-interrupt pops the stack and loads the PC with the popped top.
// - return-from-interrupt sets the global interrupt enable, bit 7 of interrupt control.
// - return-from-interrupt is one word and takes two instruction cycles.
// - return-with-literal loads W with the low-byte immediate; bits 9:8 ignored.
// - return-with-literal loads the PC from the stack top, two cycles, no flags.
// - rotate-left shifts the file register left through carry; only carry changes.
// - rotate-left destination bit zero writes W, one writes the file register.
// - file-register results go to W on destination zero, else back to the file.
module rre_core #(
    parameter int STACK_DEPTH = rre_pkg::STACK_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [rre_pkg::INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    input wire logic push_i,
    input wire logic [rre_pkg::PC_W-1:0] push_pc_i,
    input wire logic gie_clr_i,
    output logic [rre_pkg::FADDR_W-1:0] file_rd_addr_o,
    input wire logic [rre_pkg::DATA_W-1:0] file_rd_data_i,
    output logic file_wr_en_o,
    output logic [rre_pkg::FADDR_W-1:0] file_wr_addr_o,
    output logic [rre_pkg::DATA_W-1:0] file_wr_data_o,
    output logic [rre_pkg::PC_W-1:0] pc_o,
    output logic pc_load_o,
    output logic [rre_pkg::DATA_W-1:0] w_o,
    output logic carry_o,
    output logic [rre_pkg::DATA_W-1:0] int_ctrl_gie_o
);
    // the stack model needs room for at least two returns
    generate
        if (STACK_DEPTH < 2) begin : g_bad_depth
            $error("rre_core: STACK_DEPTH must be at least 2");
        end
        // the sequencer holds a return for exactly one stall cycle
        if (rre_pkg::RET_CYCLES != 2) begin : g_bad_ret_cycles
            $error("rre_core: returns are built for two cycles");
        end
        // rotates retire at the taking edge, there is no stall state for them
        if (rre_pkg::ROT_CYCLES != 1) begin : g_bad_rot_cycles
            $error("rre_core: rotates are built for one cycle");
        end
        // destination bit must sit just above the file address field
        if (rre_pkg::DEST_BIT != rre_pkg::FADDR_W) begin : g_bad_dest_bit
            $error("rre_core: destination bit must follow the file address");
        end
        // carry leaves from the top data bit
        if (rre_pkg::MSB_BIT != rre_pkg::DATA_W - 1) begin : g_bad_msb_bit
            $error("rre_core: carry must come from the top data bit");
        end
        // enable bit must fit inside the interrupt control image
        if (rre_pkg::GIE_BIT >= rre_pkg::DATA_W) begin : g_bad_gie_bit
            $error("rre_core: enable bit outside the control image");
        end
    endgenerate

    typedef struct packed {
        rre_pkg::rre_state_e state;
        logic is_lit;
        logic [rre_pkg::DATA_W-1:0] lit;
        logic [rre_pkg::DATA_W-1:0] w;
        logic carry;
        logic global_interrupt_enable;
        logic [rre_pkg::PC_W-1:0] pc;
        logic pc_load;
        logic wr_en;
        logic [rre_pkg::FADDR_W-1:0] wr_addr;
        logic [rre_pkg::DATA_W-1:0] wr_data;
    } rre_core_s;

    rre_core_s core_reg;
    rre_core_s core_next;
    rre_pkg::rre_op_e op;
    logic take;
    logic pop;
    logic [rre_pkg::PC_W-1:0] stack_top;
    logic [rre_pkg::DATA_W-1:0] rot_res;

    // classify an instruction word
    function automatic rre_pkg::rre_op_e rre_decode(input logic [rre_pkg::INSTR_W-1:0] iw);
        rre_pkg::rre_op_e res;
        res = rre_pkg::RRE_OP_NONE;
        if (iw == rre_pkg::OPC_RET_INT) begin
            res = rre_pkg::RRE_OP_RET_INT;
        end else if ((iw & rre_pkg::OPC_RET_LIT_MASK) == rre_pkg::OPC_RET_LIT_VAL) begin
            res = rre_pkg::RRE_OP_RET_LIT;
        end else if ((iw & rre_pkg::OPC_ROT_MASK) == rre_pkg::OPC_ROT_VAL) begin
            res = rre_pkg::RRE_OP_ROT;
        end
        return res;
    endfunction : rre_decode

    // true for the two-cycle returns
    function automatic logic rre_is_return(input rre_pkg::rre_op_e o);
        return (o == rre_pkg::RRE_OP_RET_INT) || (o == rre_pkg::RRE_OP_RET_LIT);
    endfunction : rre_is_return

    // rotate one place left through carry
    function automatic logic [rre_pkg::DATA_W-1:0] rre_rotl(
        input logic [rre_pkg::DATA_W-1:0] v,
        input logic ci
    );
        return {v[rre_pkg::DATA_W-2:0], ci};
    endfunction : rre_rotl

    // handshake and decode
    assign op = rre_decode(instr_i);
    assign instr_ready_o = (core_reg.state == rre_pkg::RRE_ST_IDLE);
    assign take = instr_valid_i && instr_ready_o;
    // pop only on an enabled take; a push in the same cycle wins
    assign pop = ce_i && take && rre_is_return(op);
    assign file_rd_addr_o = instr_i[rre_pkg::FADDR_W-1:0];
    // old carry into bit 0, old msb out to carry
    assign rot_res = rre_rotl(file_rd_data_i, core_reg.carry);

    rre_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(rre_pkg::PC_W)
    ) u_stack (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .push_i(push_i),
        .push_data_i(push_pc_i),
        .pop_i(pop),
        .rd_data_o(stack_top)
    );

    // sequencer and execute
    always_comb begin
        core_next = core_reg;
        core_next.pc_load = 1'b0;
        core_next.wr_en = 1'b0;
        // external clear first, so a return's set further down wins the edge
        if (gie_clr_i) begin
            core_next.global_interrupt_enable = 1'b0;
        end
        case (core_reg.state)
            rre_pkg::RRE_ST_IDLE: begin
                if (take) begin
                    case (op)
                        rre_pkg::RRE_OP_RET_INT: begin
                            core_next.state = rre_pkg::RRE_ST_RET;
                            core_next.is_lit = 1'b0;
                        end
                        rre_pkg::RRE_OP_RET_LIT: begin
                            core_next.state = rre_pkg::RRE_ST_RET;
                            core_next.is_lit = 1'b1;
                            core_next.lit = instr_i[rre_pkg::DATA_W-1:0];
                        end
                        rre_pkg::RRE_OP_ROT: begin
                            core_next.carry = file_rd_data_i[rre_pkg::MSB_BIT];
                            if (instr_i[rre_pkg::DEST_BIT]) begin
                                core_next.wr_en = 1'b1;
                                core_next.wr_addr = instr_i[rre_pkg::FADDR_W-1:0];
                                core_next.wr_data = rot_res;
                            end else begin
                                core_next.w = rot_res;
                            end
                        end
                        default: begin
                            core_next.state = rre_pkg::RRE_ST_IDLE;
                        end
                    endcase
                end
            end
            rre_pkg::RRE_ST_RET: begin
                // second cycle: popped top is now registered
                core_next.state = rre_pkg::RRE_ST_IDLE;
                core_next.pc = stack_top;
                core_next.pc_load = 1'b1;
                if (core_reg.is_lit) begin
                    core_next.w = core_reg.lit;
                end else begin
                    core_next.global_interrupt_enable = 1'b1;
                end
            end
            default: begin
                core_next.state = rre_pkg::RRE_ST_IDLE;
            end
        endcase
    end

    // state register, frozen while the enable is low
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // named reset values laid over an all-zero image
            core_reg <= '0;
            core_reg.state <= rre_pkg::RRE_ST_IDLE;
            core_reg.w <= rre_pkg::W_RST;
            core_reg.carry <= rre_pkg::CARRY_RST;
            core_reg.global_interrupt_enable <= rre_pkg::GIE_RST;
            core_reg.pc <= rre_pkg::PC_RST;
        end else if (ce_i) begin
            core_reg <= core_next;
        end
    end

    // registered outputs
    assign file_wr_en_o = core_reg.wr_en;
    assign file_wr_addr_o = core_reg.wr_addr;
    assign file_wr_data_o = core_reg.wr_data;
    assign pc_o = core_reg.pc;
    assign pc_load_o = core_reg.pc_load;
    assign w_o = core_reg.w;
    assign carry_o = core_reg.carry;
    // interrupt control image: only the enable bit is owned here
    always_comb begin
        int_ctrl_gie_o = '0;
        int_ctrl_gie_o[rre_pkg::GIE_BIT] = core_reg.global_interrupt_enable;
    end
endmodule : rre_core

// ---- sim/rre_core_props.sv ----
/* rre_core_props: port assertions for rre_core.
   assumes a single clock and the async active-low reset. */
`timescale 1ns/1ps
module rre_core_props #(
    parameter int STACK_DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [13:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic instr_ready_o,
    input wire logic push_i,
    input wire logic [12:0] push_pc_i,
    input wire logic gie_clr_i,
    input wire logic [6:0] file_rd_addr_o,
    input wire logic [7:0] file_rd_data_i,
    input wire logic file_wr_en_o,
    input wire logic [6:0] file_wr_addr_o,
    input wire logic [7:0] file_wr_data_o,
    input wire logic [12:0] pc_o,
    input wire logic pc_load_o,
    input wire logic [7:0] w_o,
    input wire logic carry_o,
    input wire logic [7:0] int_ctrl_gie_o
);
    // decoded takes and rotate result
    wire tk = ce_i && instr_valid_i && instr_ready_o;
    wire t_ri = tk && instr_i == rre_pkg::OPC_RET_INT;
    wire t_rl = tk && (instr_i & rre_pkg::OPC_RET_LIT_MASK) == rre_pkg::OPC_RET_LIT_VAL;
    wire t_rot = tk && (instr_i & rre_pkg::OPC_ROT_MASK) == rre_pkg::OPC_ROT_VAL;
    wire [7:0] rot = {file_rd_data_i[6:0], carry_o};
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // stall cycle then pc load
    sequence s_ret;
        !instr_ready_o ##1 pc_load_o;
    endsequence
    a_ret_int_gie: assert property (t_ri |=> s_ret ##0 int_ctrl_gie_o[7])
        else $error("return from interrupt wrong");
    a_ret_lit_w: assert property (t_rl |=> s_ret ##0 w_o == $past(instr_i[7:0], 2))
        else $error("literal return wrong");
    a_ret_lit_flags: assert property (t_rl |=> $stable(carry_o) [*2])
        else $error("literal return moved carry");
    a_rot_carry: assert property (t_rot |=> carry_o == $past(file_rd_data_i[7]))
        else $error("rotate carry wrong");
    a_rot_to_w: assert property (t_rot && !instr_i[7] |=> !file_wr_en_o && w_o == $past(rot))
        else $error("rotate to w wrong");
    a_rot_to_file: assert property (t_rot && instr_i[7] |=> file_wr_en_o &&
        file_wr_data_o == $past(rot) && file_wr_addr_o == $past(instr_i[6:0]))
        else $error("rotate to file wrong");
    a_ready_gap: assert property (ce_i && !instr_ready_o |=> instr_ready_o)
        else $error("stall longer than one cycle");
    a_rd_addr: assert property (file_rd_addr_o == instr_i[6:0])
        else $error("file read address wrong");
endmodule : rre_core_props

bind rre_core rre_core_props #(
    .STACK_DEPTH(STACK_DEPTH)
) u_rre_core_props (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o),
    .push_i(push_i),
    .push_pc_i(push_pc_i),
    .gie_clr_i(gie_clr_i),
    .file_rd_addr_o(file_rd_addr_o),
    .file_rd_data_i(file_rd_data_i),
    .file_wr_en_o(file_wr_en_o),
    .file_wr_addr_o(file_wr_addr_o),
    .file_wr_data_o(file_wr_data_o),
    .pc_o(pc_o),
    .pc_load_o(pc_load_o),
    .w_o(w_o),
    .carry_o(carry_o),
    .int_ctrl_gie_o(int_ctrl_gie_o)
);

// ---- sim/tb_rre_core.sv ----
/* tb_rre_core: random and corner tests of rre_core.
   assumes the checker is bound in; ce stays high. */
`timescale 1ns/1ps
module tb_rre_core;
    logic clk, rst_n, ce, vld, push, gclr, rdy, wen, ld, c, ec;
    logic [13:0] ins;
    logic [12:0] ppc, pc, a;
    logic [6:0] rda, wa;
    logic [7:0] rdd, wd, w, global_interrupt_enable, ew, d;
    logic [8:0] x;
    logic [31:0] r;
    int errors, checks_done, cyc, seed;
    rre_core u_rre_core (.core_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce), .instr_i(ins),
        .instr_valid_i(vld), .instr_ready_o(rdy), .push_i(push), .push_pc_i(ppc),
        .gie_clr_i(gclr), .file_rd_addr_o(rda), .file_rd_data_i(rdd), .file_wr_en_o(wen),
        .file_wr_addr_o(wa), .file_wr_data_o(wd), .pc_o(pc), .pc_load_o(ld), .w_o(w),
        .carry_o(c), .int_ctrl_gie_o(global_interrupt_enable));
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            test_done();
        end
    end
    task chk(string n, logic [12:0] s, logic [12:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task do_push(logic [12:0] v);
        @(posedge clk);
        push <= 1'b1;
        ppc <= v;
        @(posedge clk);
        push <= 1'b0;
    endtask : do_push
    // offer one word, return just after the taking edge
    task exec(logic [13:0] i, logic [7:0] dd);
        @(posedge clk);
        ins <= i;
        rdd <= dd;
        vld <= 1'b1;
        // hold the offer until an edge samples ready high
        do @(posedge clk); while (rdy !== 1'b1);
        vld <= 1'b0;
        #1;
    endtask : exec
    task ret(logic [13:0] i, logic [12:0] e);
        exec(i, r[15:8]);
        chk("ready", rdy, 0);
        @(posedge clk);
        #1;
        chk("pc", pc, e);
        chk("load", ld, 1);
    endtask : ret
    // carry out on top, rotated byte below
    function logic [8:0] rot_exp(logic [7:0] v, logic ci);
        return {v, ci};
    endfunction : rot_exp
    initial begin
        seed = 32'h58cd3fec;
        {errors, checks_done, cyc} = '0;
        {rst_n, vld, push, gclr, ec} = '0;
        {ins, ppc, rdd, ew} = '0;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("w0", w, 0);
        chk("gie0", global_interrupt_enable, 0);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            a = r[28:16];
            case (i < 4 ? 2'd2 : r[1:0])
                2'd0: begin
                    do_push(a);
                    do_push(~a);
                    gclr <= 1'b1;
                    @(posedge clk);
                    gclr <= 1'b0;
                    #1;
                    chk("gie", global_interrupt_enable, 8'h00);
                    ret(rre_pkg::OPC_RET_INT, ~a);
                    chk("gie", global_interrupt_enable, 8'h80);
                    // clear held across the set edge: the set must win
                    @(posedge clk);
                    gclr <= 1'b1;
                    ret(rre_pkg::OPC_RET_INT, a);
                    chk("gie", global_interrupt_enable, 8'h80);
                    @(posedge clk);
                    gclr <= 1'b0;
                end
                2'd1: begin
                    do_push(a);
                    ret({4'hd, r[9:0]}, a);
                    chk("w", w, r[7:0]);
                    chk("c", c, ec);
                    ew = r[7:0];
                end
                default: begin
                    d = i < 4 ? 8'h80 ^ {8{i[0]}} : r[23:16];
                    x = rot_exp(d, ec);
                    exec({6'h0d, i < 4 ? i[1] : r[7], r[6:0]}, d);
                    chk("c", c, x[8]);
                    chk("wen", wen, ins[7]);
                    if (ins[7]) begin
                        chk("wa", wa, r[6:0]);
                        chk("wd", wd, x[7:0]);
                    end else ew = x[7:0];
                    chk("w", w, ew);
                    ec = x[8];
                end
            endcase
        end
        test_done();
    end
endmodule : tb_rre_core
